/* rtl/serial_adc_conversion_sequencer.sv */
`timescale 1ns/1ps
module serial_adc_conversion_sequencer (
  // Clocking
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Host serial pins
  input wire logic sel_n,
  input wire logic sclk,
  output logic dout,
  output logic dout_oe,
  // Analog front end
  output logic sample_en,
  output logic [adc_seq_pkg::RES_BITS-1:0] dac_trial,
  input wire logic cmp_high,
  input wire logic above_ref,
  input wire logic below_ref,
  // Result stream
  output logic res_valid,
  input wire logic res_ready,
  output logic [adc_seq_pkg::RES_BITS-1:0] res_data,
  // Status
  output logic busy
);
  import adc_seq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers.

  logic sel_s1, sel_s2, sel_s3, sel_agree;
  logic sck_s1, sck_s2, sck_s3, sck_agree;
  logic next_sel_agree, next_sck_agree;

  always_comb begin
    next_sel_agree = agree(sel_s2, sel_s3, sel_agree);
    next_sck_agree = agree(sck_s2, sck_s3, sck_agree);
  end

  // Select resets deselected and the shift clock low, their idle levels, so no false edge follows reset.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_s1 <= 1'b1;
      sel_s2 <= 1'b1;
      sel_s3 <= 1'b1;
      sel_agree <= 1'b1;
      sck_s1 <= 1'b0;
      sck_s2 <= 1'b0;
      sck_s3 <= 1'b0;
      sck_agree <= 1'b0;
    end else if (ce) begin
      sel_s1 <= sel_n;
      sel_s2 <= sel_s1;
      sel_s3 <= sel_s2;
      sel_agree <= next_sel_agree;
      sck_s1 <= sclk;
      sck_s2 <= sck_s1;
      sck_s3 <= sck_s2;
      sck_agree <= next_sck_agree;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Select noise filter.

  logic sel_filt, next_sel_filt;
  logic [5:0] filt_cnt, next_filt_cnt;
  logic accept_fall, accept_rise, sck_fall;

  always_comb begin
    next_sel_filt = sel_filt;
    next_filt_cnt = '0;
    accept_fall = 1'b0;
    accept_rise = 1'b0;
    if (sel_agree != sel_filt) begin
      if (filt_cnt == 6'(SEL_FILT_CYC - 1)) begin
        next_sel_filt = sel_agree;
        accept_fall = !sel_agree;
        accept_rise = sel_agree;
      end else begin
        next_filt_cnt = filt_cnt + 6'h01;
      end
    end
    // The shift clock only counts while the filtered select is low.
    sck_fall = !sel_filt && sck_agree && !next_sck_agree;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_filt <= 1'b1;
      filt_cnt <= '0;
    end else if (ce) begin
      sel_filt <= next_sel_filt;
      filt_cnt <= next_filt_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer: access and sampling, bit decisions, result store.

  seq_state_t state, next_state;
  logic [4:0] fall_cnt, next_fall_cnt;
  logic [RES_BITS-1:0] sar, next_sar;
  logic [3:0] bit_idx, next_bit_idx;
  logic [8:0] step_cnt, next_step_cnt;
  logic [RES_BITS-1:0] result, next_result;
  logic [RES_BITS-1:0] shift, next_shift;
  logic fifo_in_valid, fifo_in_ready;
  logic [RES_BITS-1:0] clamped;

  always_comb begin
    next_state = state;
    next_fall_cnt = fall_cnt;
    next_sar = sar;
    next_bit_idx = bit_idx;
    next_step_cnt = step_cnt;
    next_result = result;
    next_shift = shift;
    fifo_in_valid = 1'b0;
    clamped = above_ref ? CODE_FULL : (below_ref ? CODE_ZERO : sar);
    if (accept_fall) begin
      // A believed select fall restarts from scratch and drops any conversion in flight.
      next_state = ST_ACCESS;
      next_fall_cnt = '0;
      next_sar = '0;
      next_step_cnt = '0;
    end else begin
      case (state)
        ST_IDLE: begin
          next_state = ST_IDLE;
        end
        ST_ACCESS: begin
          if (accept_rise) begin
            // Too few clocks: no conversion starts.
            next_state = ST_IDLE;
          end else if (sck_fall && fall_cnt < 5'(MAX_CLOCKS)) begin
            next_fall_cnt = fall_cnt + 5'h01;
            next_shift = {shift[RES_BITS-2:0], 1'b0};
            if (next_fall_cnt == 5'(SAMPLE_END_FALL)) begin
              next_state = ST_CONVERT;
              next_bit_idx = 4'(RES_BITS - 1);
              next_sar = CODE_ZERO;
              next_sar[RES_BITS-1] = 1'b1;
              next_step_cnt = '0;
            end
          end
        end
        ST_CONVERT: begin
          // Clocks after the tenth are not looked at here.
          if (step_cnt == 9'(STEP_CYC - 1)) begin
            next_step_cnt = '0;
            next_sar[bit_idx] = cmp_high;
            if (bit_idx == 4'h0) begin
              next_state = ST_STORE;
            end else begin
              next_bit_idx = bit_idx - 4'h1;
              next_sar[bit_idx - 4'h1] = 1'b1;
            end
          end else begin
            next_step_cnt = step_cnt + 9'h001;
          end
        end
        ST_STORE: begin
          // A full result stream stalls here; drain it to keep within the conversion budget.
          fifo_in_valid = 1'b1;
          if (fifo_in_ready) begin
            next_result = clamped;
            next_state = ST_IDLE;
          end
        end
        default: begin
          next_state = ST_IDLE;
        end
      endcase
    end
    // Outside an access the shifter mirrors the result, so the MSB is ready when select drops.
    if (next_state != ST_ACCESS) begin
      next_shift = next_result;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      fall_cnt <= '0;
      sar <= '0;
      bit_idx <= '0;
      step_cnt <= '0;
      result <= RESULT_RESET;
      shift <= RESULT_RESET;
    end else if (ce) begin
      state <= next_state;
      fall_cnt <= next_fall_cnt;
      sar <= next_sar;
      bit_idx <= next_bit_idx;
      step_cnt <= next_step_cnt;
      result <= next_result;
      shift <= next_shift;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.

  // The driver follows the synchronised select, not the filtered one, to meet the enable time.
  assign dout_oe = !sel_agree;
  assign dout = shift[RES_BITS-1];
  assign sample_en = (state == ST_ACCESS) && (fall_cnt >= 5'(SAMPLE_START_FALL));
  assign dac_trial = sar;
  assign busy = (state == ST_CONVERT) || (state == ST_STORE);

  sample_fifo #(
    .WIDTH(RES_BITS),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .in_data(clamped),
    .out_valid(res_valid),
    .out_ready(res_ready),
    .out_data(res_data)
  );

endmodule : serial_adc_conversion_sequencer

/* rtl/adc_seq_pkg.sv */
package adc_seq_pkg;

  localparam int CLK_MHZ = 20;
  localparam int RES_BITS = 10;
  localparam int MAX_CLOCKS = 16;
  localparam int SAMPLE_START_FALL = 3;
  localparam int SAMPLE_END_FALL = 10;
  localparam int FIFO_DEPTH = 32;

  // Select must hold this long before a change is believed; rounded up.
  localparam int SEL_FILT_NS = 1425;
  localparam int SEL_FILT_CYC = (SEL_FILT_NS * CLK_MHZ + 999) / 1000;

  // Conversion budget; rounded down, split over the bit decisions plus margin.
  localparam int CONV_NS = 21000;
  localparam int CONV_CYC = (CONV_NS * CLK_MHZ) / 1000;
  localparam int STEP_CYC = CONV_CYC / (RES_BITS + 1);

  localparam logic [9:0] CODE_FULL = 10'h3FF;
  localparam logic [9:0] CODE_ZERO = 10'h000;
  localparam logic [9:0] RESULT_RESET = 10'h000;

  typedef enum logic [1:0] {ST_IDLE, ST_ACCESS, ST_CONVERT, ST_STORE} seq_state_t;

  // Agreed level of a three-stage synchroniser: moves only when stages two and three match.
  function automatic logic agree(input logic s2, input logic s3, input logic cur);
    agree = (s2 == s3) ? s3 : cur;
  endfunction : agree

endpackage : adc_seq_pkg

/* rtl/sample_fifo.sv */
`timescale 1ns/1ps
module sample_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 32
) (
  // Clocking
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
  logic [AW:0] count, next_count;
  logic push, pop;

  assign in_ready = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];

  always_comb begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? ((wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1)) : wr_ptr;
    next_rd_ptr = pop ? ((rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1)) : rd_ptr;
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else if (ce) begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
    end
  end

  // Storage has no reset; out_data is only meaningful while out_valid is high.
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wr_ptr] <= in_data;
    end
  end

endmodule : sample_fifo

/* bench/serial_adc_conversion_sequencer_checker.sv */
`timescale 1ns/1ps
module serial_adc_conversion_sequencer_checker (
  // Watched pins
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic dout,
  input wire logic dout_oe,
  input wire logic sample_en,
  input wire logic res_valid,
  input wire logic busy,
  // Clock enable
  input wire logic ce
);
  import adc_seq_pkg::*;
  logic [5:0] lo_cnt, hi_cnt, next_lo, next_hi;
  logic [4:0] fcnt, next_fcnt;
  logic sclk_q;
  // The select level counters saturate, so a long idle never wraps into a false window.
  always_comb begin
    next_lo = sel_n ? 6'h00 : lo_cnt + {5'h00, lo_cnt != 6'h3F};
    next_hi = sel_n ? hi_cnt + {5'h00, hi_cnt != 6'h3F} : 6'h00;
    next_fcnt = sel_n ? 5'h00 : fcnt + {4'h0, sclk_q && !sclk && lo_cnt >= SEL_FILT_CYC};
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lo_cnt <= 6'h00;
      hi_cnt <= 6'h3F;
      fcnt <= 5'h00;
      sclk_q <= 1'b0;
    end else begin
      lo_cnt <= next_lo;
      hi_cnt <= next_hi;
      fcnt <= next_fcnt;
      sclk_q <= sclk;
    end
  end
  default clocking cb @(posedge clk); endclocking
  // A frozen block cannot be held to its cycle counts, so checking pauses with it.
  default disable iff (!rst_n || !ce);
  sequence s_lo; !sel_n [*3]; endsequence
  sequence s_hi; sel_n [*3]; endsequence
  property p_oe_on; $fell(sel_n) ##1 s_lo |=> dout_oe; endproperty
  a_oe_on: assert property (p_oe_on) else $error("oe late");
  property p_oe_off; $rose(sel_n) ##1 s_hi |=> !dout_oe; endproperty
  a_oe_off: assert property (p_oe_off) else $error("oe held");
  property p_samp_on; $rose(sample_en) |-> fcnt == 5'h03 && lo_cnt >= SEL_FILT_CYC; endproperty
  a_samp_on: assert property (p_samp_on) else $error("sample start");
  property p_samp_off; $fell(sample_en) && !sel_n |-> fcnt == 5'h0A && busy; endproperty
  a_samp_off: assert property (p_samp_off) else $error("sample end");
  property p_conv; $rose(busy) && !res_valid |-> ##[1:420] !busy; endproperty
  a_conv: assert property (p_conv) else $error("conversion long");
  // A high phase of the shift clock spans four samples, so three in a row are always reached.
  property p_dout_hold; sclk [*3] |-> $stable(dout); endproperty
  a_dout_hold: assert property (p_dout_hold) else $error("dout moved");
  property p_sel_off; hi_cnt > SEL_FILT_CYC + 4 |-> !sample_en; endproperty
  a_sel_off: assert property (p_sel_off) else $error("clock live");
  property p_abort; lo_cnt == SEL_FILT_CYC + 8 |-> !busy; endproperty
  a_abort: assert property (p_abort) else $error("no restart");
endmodule : serial_adc_conversion_sequencer_checker
////////////////////////////////
bind serial_adc_conversion_sequencer serial_adc_conversion_sequencer_checker chk_u (
  .clk, .rst_n, .sel_n, .sclk, .dout, .dout_oe, .sample_en, .res_valid, .busy, .ce
);

/* bench/adc_host_model.sv */
`timescale 1ns/1ps
module adc_host_model (
  // Clocking
  input wire logic clk,
  // Serial pins
  output logic sel_n,
  output logic sclk,
  input wire logic dout,
  input wire logic dout_oe
);
  // The shift clock stands low outside frames.
  initial begin
    sel_n = 1'b1;
    sclk = 1'b0;
  end
  // Bits are taken late in the high phase, long after the device has shifted.
  task automatic xfer(input int lead, input int n, output logic [9:0] got);
    got = 10'h000;
    @(posedge clk) sel_n <= 1'b0;
    repeat (lead) @(posedge clk);
    for (int k = 0; k < n; k++) begin
      @(posedge clk) sclk <= 1'b1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      if (k < 10) got = {got[8:0], dout_oe ? dout : 1'bx};
      @(posedge clk) sclk <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    @(posedge clk) sel_n <= 1'b1;
  endtask : xfer
endmodule : adc_host_model

/* bench/tb_serial_adc_conversion_sequencer.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_serial_adc_conversion_sequencer;
  import adc_seq_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cmp_high = 1'b0;
  logic above_ref = 1'b0;
  logic below_ref = 1'b0;
  logic res_ready = 1'b0;
  logic ce = 1'b1;
  logic sel_n, sclk, dout, dout_oe, sample_en, res_valid, busy;
  logic [9:0] dac_trial, res_data, got;
  logic [9:0] ain = 10'h000;
  logic [9:0] last = RESULT_RESET;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  serial_adc_conversion_sequencer dut_u (.clk, .rst_n, .ce, .sel_n, .sclk, .dout, .dout_oe, .sample_en,
    .dac_trial, .cmp_high, .above_ref, .below_ref, .res_valid, .res_ready, .res_data, .busy);
  adc_host_model host_u (.clk, .sel_n, .sclk, .dout, .dout_oe);
  // The comparator answers a clock late; each trial word settles long before its decision.
  always @(posedge clk) cmp_high <= (ain >= dac_trial);
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  ////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  task automatic settle();
    int i = 0;
    @(negedge clk);
    while (busy !== 1'b0 && i < 500) begin
      @(negedge clk);
      i++;
    end
    `CHK("conv", 1'b1, i < 421)
  endtask : settle
  task automatic pop(input logic [9:0] e);
    @(negedge clk);
    `CHK("valid", 1'b1, res_valid)
    `CHK("data", e, res_data)
    @(posedge clk) res_ready <= 1'b1;
    @(posedge clk) res_ready <= 1'b0;
  endtask : pop
  task automatic empty();
    @(negedge clk);
    `CHK("empty", 1'b0, res_valid)
  endtask : empty
  // Reads the previous result back while starting a conversion of v.
  task automatic run(input logic [9:0] v, input int n, input int mode);
    @(posedge clk) ain <= v;
    host_u.xfer(40, n, got);
    `CHK("bits", last, got)
    last = above_ref ? CODE_FULL : below_ref ? CODE_ZERO : v;
    if (mode > 0) settle();
    if (mode > 1) pop(last);
  endtask : run
  ////////////////////////////////
  task automatic t_basic();
    run(10'h2A5, 10, 2);
    run(10'h15A, 16, 2);
    run(10'h000, 10, 2);
  endtask : t_basic
  task automatic t_clamp();
    for (int i = 1; i < 3; i++) begin
      @(posedge clk) {above_ref, below_ref} <= i[1:0];
      run(10'h123, 10, 2);
    end
    @(posedge clk) {above_ref, below_ref} <= 2'b00;
  endtask : t_clamp
  // Ten clocks, three of them inside the select filter time: too few are counted to start a conversion.
  task automatic t_early();
    host_u.xfer(2, 10, got);
    repeat (40) @(posedge clk);
    empty();
    `CHK("idle", 1'b0, busy)
  endtask : t_early
  task automatic t_abort();
    logic [9:0] prev;
    prev = last;
    run(10'h0F0, 10, 0);
    last = prev;
    repeat (40) @(posedge clk);
    run(10'h30C, 10, 2);
    empty();
  endtask : t_abort
  // A low clock enable must stretch a conversion past its budget without disturbing its result.
  task automatic t_freeze();
    run(10'h2D2, 10, 0);
    repeat (60) @(posedge clk);
    @(posedge clk) ce <= 1'b0;
    repeat (400) @(posedge clk);
    @(negedge clk);
    `CHK("frozen", 1'b1, busy)
    @(posedge clk) ce <= 1'b1;
    settle();
    pop(last);
  endtask : t_freeze
  task automatic t_fifo();
    for (int i = 0; i <= FIFO_DEPTH; i++)
      run(10'h100 + i[9:0], 10, i < FIFO_DEPTH);
    repeat (450) @(posedge clk);
    @(negedge clk);
    `CHK("stall", 1'b1, busy)
    for (int i = 0; i <= FIFO_DEPTH; i++)
      pop(10'h100 + i[9:0]);
    empty();
  endtask : t_fifo
  initial begin
    repeat (3) @(posedge clk);
    @(negedge clk);
    `CHK("rst oe", 1'b0, dout_oe)
    @(posedge clk) rst_n <= 1'b1;
    t_basic();
    t_clamp();
    t_early();
    t_abort();
    t_freeze();
    t_fifo();
    tally_and_finish();
  end
endmodule : tb_serial_adc_conversion_sequencer
